//--- dv/haptic_state_trigger_control_bench.sv
`timescale 1ns/1ps
module haptic_state_trigger_control_bench;
   localparam int IW = 20;
   localparam int SW = 10;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, seq_done, short_det, temp_warn;
   logic temp_crit, fault_interrupt_n, bridge_out_positive, bridge_out_negative, bridge_oe;
   logic bemf_monitor_en;
   logic [7:0] avs_address, imped_meas, supply_meas, wave_shape, drive_level;
   logic [31:0] avs_writedata, avs_readdata, d;
   logic [2:0] trigger_input, loop_fault, active_seq;
   logic [3:0] closed_loop_feat;
   logic [1:0] sys_state;
   int fail_count = 0;
   int checks_done = 0;
   int n;
   hsc_top #(.IDLE_WAKE(IW), .STBY_WAKE(SW)) u_dut (.clk, .rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .trigger_input, .seq_done,
      .imped_meas, .supply_meas, .loop_fault, .short_det, .temp_warn, .temp_crit,
      .fault_interrupt_n, .bridge_out_positive, .bridge_out_negative, .bridge_oe,
      .bemf_monitor_en, .closed_loop_feat, .wave_shape, .drive_level, .active_seq, .sys_state);
   hsc_host u_host (.clk, .avs_readdata, .avs_waitrequest, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .trigger_input);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      u_host.acc(1'b1, a, v, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      u_host.acc(1'b0, a, 32'h0, v);
   endtask
   task automatic wait_st(input logic [1:0] s, input int lim);
      n = 0;
      while (sys_state !== s && n < lim) begin
         tick();
         n++;
      end
   endtask
   task automatic done_seq(input logic [1:0] s);
      @(posedge clk);
      seq_done <= 1'b1;
      repeat (2) @(posedge clk);
      seq_done <= 1'b0;
      wait_st(s, 8);
      chk(32'(sys_state), 32'(s));
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      loop_fault <= k == 0 ? 3'h1 : 3'h0;
      short_det <= k == 1;
      temp_crit <= k == 2;
      repeat (3) @(posedge clk);
      {loop_fault, short_det, temp_crit} <= 5'h00;
      wait_st(2'h1, 8);
      chk(32'(sys_state), 32'h1);
      chk(32'(bridge_oe), 32'h0);
   endtask
   task automatic t_boot();
      wait_st(2'h1, 10);
      chk(32'(sys_state), 32'h1);
      rd(hsc_pkg::A_SHAPE, d);
      chk(d, 32'(hsc_pkg::SHAPE_SINE));
      rd(8'h30, d);
      chk(d, 32'h0);
      wr(hsc_pkg::A_MEM, 32'ha5);
      wr(8'(hsc_pkg::A_MEM + hsc_pkg::WAVE_BYTES - 1), 32'h5a);
      wr(hsc_pkg::A_LEVEL, 32'h80);
      repeat (3) tick();
      chk(32'(drive_level), 32'h40);
      @(posedge clk);
      supply_meas <= 8'hff;
      repeat (3) tick();
      chk(32'(drive_level), 32'h80);
   endtask
   task automatic t_reg();
      wr(hsc_pkg::A_MODE, 32'(hsc_pkg::MODE_REGMEM));
      imped_meas <= 8'h3c;
      wr(hsc_pkg::A_START, 32'h5);
      wait_st(2'h3, IW + 8);
      chk(32'(n <= IW), 32'h1);
      chk(32'(active_seq), 32'h5);
      rd(hsc_pkg::A_IMPED, d);
      chk(d, 32'h3c);
      chk(32'(bridge_oe), 32'h1);
      chk(32'({bemf_monitor_en, wave_shape}), 32'h1);
      wr(hsc_pkg::A_START, 32'h2);
      repeat (600) tick();
      chk(32'({sys_state, active_seq}), 32'h1d);
      done_seq(2'h1);
      rd(hsc_pkg::A_MEM, d);
      chk(d, 32'ha5);
      rd(8'(hsc_pkg::A_MEM + hsc_pkg::WAVE_BYTES - 1), d);
      chk(d, 32'h5a);
   endtask
   task automatic t_stby();
      wr(hsc_pkg::A_CTRL, 32'h1);
      wr(hsc_pkg::A_START, 32'h4);
      wait_st(2'h3, IW + 8);
      done_seq(2'h2);
      wr(hsc_pkg::A_START, 32'h1);
      wait_st(2'h3, SW + 8);
      chk(32'(n <= SW), 32'h1);
      done_seq(2'h2);
      wr(hsc_pkg::A_CTRL, 32'h0);
   endtask
   task automatic t_trig();
      logic [1:0] pn [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
      logic       pv [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      logic [2:0] ps [7] = '{3'h2, 3'h7, 3'h3, 3'h7, 3'h4, 3'h0, 3'h0};
      wr(hsc_pkg::A_MODE, 32'(hsc_pkg::MODE_EDGEMEM));
      wr(hsc_pkg::A_TRIG, 32'h79);
      wr(hsc_pkg::A_SEQ, 32'h22);
      for (int i = 0; i < 7; i++) begin
         u_host.pin(pn[i], pv[i]);
         wait_st(2'h3, IW + 8);
         if (ps[i] == 3'h7) begin
            chk(32'(sys_state !== 2'h3), 32'h1);
         end else begin
            chk(32'(active_seq), 32'(ps[i]));
            done_seq(2'h1);
         end
      end
   endtask
   task automatic t_fault();
      wr(hsc_pkg::A_CTRL, 32'ha4);
      tick();
      chk(32'({closed_loop_feat, bemf_monitor_en, wave_shape}), 32'h1500);
      wr(hsc_pkg::A_MODE, 32'(hsc_pkg::MODE_REGMEM));
      wr(hsc_pkg::A_START, 32'h1);
      wait_st(2'h3, IW + 8);
      pulse(0);
      chk(32'(fault_interrupt_n), 32'h0);
      rd(hsc_pkg::A_FAULT, d);
      chk(d & 32'h1, 32'h1);
      wr(hsc_pkg::A_START, 32'h1);
      repeat (IW + 8) tick();
      chk(32'(sys_state), 32'h1);
      wr(hsc_pkg::A_FAULT, 32'h1);
      tick();
      chk(32'(fault_interrupt_n), 32'h1);
      wr(hsc_pkg::A_CTRL, 32'ha6);
      wr(hsc_pkg::A_START, 32'h2);
      wait_st(2'h3, IW + 8);
      pulse(1);
      wr(hsc_pkg::A_START, 32'h3);
      wait_st(2'h3, IW + 8);
      chk(32'({sys_state, active_seq}), 32'h1b);
      @(posedge clk);
      temp_warn <= 1'b1;
      rd(hsc_pkg::A_STATUS, d);
      chk(d & 32'h80, 32'h80);
      pulse(2);
      wr(hsc_pkg::A_FAULT, 32'h1f);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      seq_done = 1'b0;
      imped_meas = 8'h00;
      supply_meas = 8'h40;
      loop_fault = 3'h0;
      short_det = 1'b0;
      temp_warn = 1'b0;
      temp_crit = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_boot();
      t_reg();
      t_stby();
      t_trig();
      t_fault();
      conclude();
   end
endmodule

//--- dv/hsc_host.sv
`timescale 1ns/1ps
module hsc_host (
   input  wire logic        clk,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   output logic [7:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [2:0]       trigger_input
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      trigger_input = 3'h0;
   end
   // Request held until waitrequest is seen low at an edge
   task automatic acc(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd_d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr_en;
      avs_write <= wr_en;
      // Only the bench watchdog ends a wait that never finishes
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd_d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic pin(input logic [1:0] i, input logic v);
      @(posedge clk);
      trigger_input[i] <= v;
   endtask
endmodule

//--- dv/hsc_top_chk.sv
`timescale 1ns/1ps
module hsc_top_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic       seq_done,
   input wire logic [7:0] supply_meas,
   input wire logic [2:0] loop_fault,
   input wire logic       short_det,
   input wire logic       temp_crit,
   input wire logic       fault_interrupt_n,
   input wire logic       bridge_out_positive,
   input wire logic       bridge_oe,
   input wire logic       bemf_monitor_en,
   input wire logic [3:0] closed_loop_feat,
   input wire logic [7:0] wave_shape,
   input wire logic [7:0] drive_level,
   input wire logic [2:0] active_seq,
   input wire logic [1:0] sys_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic       pos_q;
   logic       run_r;
   logic [9:0] half_r;
   // Half period only judged over an unbroken stretch of drive
   always_ff @(posedge clk) begin
      pos_q <= bridge_out_positive;
      if (rst || !bridge_oe) begin
         run_r <= 1'b0;
         half_r <= 10'h000;
      end else if (bridge_out_positive != pos_q) begin
         run_r <= 1'b1;
         half_r <= 10'h001;
      end else begin
         half_r <= half_r + 10'h001;
      end
   end
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered after one wait state");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_boot_idle: assert property ($fell(rst) |-> ##[1:3] sys_state == 2'h1)
      else $error("no idle state after boot");
   a_short_tristate: assert property (short_det |-> ##[1:2] !bridge_oe)
      else $error("bridge still enabled on short");
   a_temp_shutdown: assert property (temp_crit |-> ##[1:3] (sys_state == 2'h1 && !fault_interrupt_n))
      else $error("over-temperature did not shut down");
   a_fault_nodrive: assert property (!fault_interrupt_n && !$past(fault_interrupt_n) |-> !bridge_oe)
      else $error("bridge enabled while a fault is flagged");
   a_drive_hold: assert property (sys_state == 2'h3 && !seq_done && !avs_write && !short_det
      && !temp_crit && loop_fault == 3'h0 |=> sys_state == 2'h3)
      else $error("drive left without completion or fault");
   a_seq_stable: assert property (sys_state == 2'h3 && $past(sys_state) == 2'h3 |-> $stable(active_seq))
      else $error("sequence changed during drive");
   a_done_exit: assert property (sys_state == 2'h3 && seq_done |-> ##[1:2] sys_state != 2'h3)
      else $error("drive kept after completion");
   a_loop_mode: assert property ((bemf_monitor_en && wave_shape == 8'h00)
      || (!bemf_monitor_en && closed_loop_feat == 4'h0))
      else $error("loop mode outputs inconsistent");
   a_level_cap: assert property (supply_meas == $past(supply_meas, 2)
      |-> drive_level <= supply_meas)
      else $error("drive level above supply");
   a_half_period: assert property (bridge_oe && run_r && bridge_out_positive != pos_q
      |-> half_r == 10'h10a)
      else $error("bridge half period wrong");
   c_drive: cover property (sys_state == 2'h3 && bridge_oe);
   c_standby: cover property (sys_state == 2'h2);
   c_fault: cover property (!fault_interrupt_n);
endmodule
bind hsc_top hsc_top_chk u_chk (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .seq_done,
   .supply_meas, .loop_fault, .short_det, .temp_crit, .fault_interrupt_n, .bridge_out_positive,
   .bridge_oe, .bemf_monitor_en, .closed_loop_feat, .wave_shape, .drive_level, .active_seq,
   .sys_state);

//--- logic/hsc_pkg.sv
package hsc_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int IDLE_WAKE_NS = 750_000;
   localparam int STBY_WAKE_NS = 150_000;
   localparam int PWM_FREQ_HZ = 187_500;
   // Longest times round down
   localparam int IDLE_WAKE_CYC = IDLE_WAKE_NS / 10;
   localparam int STBY_WAKE_CYC = STBY_WAKE_NS / 10;
   // Pin sync, start strobe and output flops sit outside the wake count
   localparam int WAKE_OVH = 6;
   localparam int PWM_DIV = CLK_HZ / PWM_FREQ_HZ;
   localparam int WAVE_BYTES = 100;
   localparam int NUM_TRIG = 3;
   localparam int NUM_SEQ = 6;

   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_MODE = 8'h04;
   localparam logic [7:0] A_TRIG = 8'h08;
   localparam logic [7:0] A_SEQ = 8'h0c;
   localparam logic [7:0] A_START = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [7:0] A_FAULT = 8'h18;
   localparam logic [7:0] A_IMPED = 8'h1c;
   localparam logic [7:0] A_SUPPLY = 8'h20;
   localparam logic [7:0] A_SHAPE = 8'h24;
   localparam logic [7:0] A_LEVEL = 8'h28;
   localparam logic [7:0] A_MEM = 8'h80;
   // One byte per address, so the store has to fit below the top of the map
   localparam logic [7:0] A_MEM_END = 8'(A_MEM + WAVE_BYTES);

   localparam logic [2:0] MODE_INACTIVE = 3'h0;
   localparam logic [2:0] MODE_STREAM = 3'h1;
   localparam logic [2:0] MODE_PWMIN = 3'h2;
   localparam logic [2:0] MODE_REGMEM = 3'h3;
   localparam logic [2:0] MODE_EDGEMEM = 3'h4;

   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;

   // Fault bits
   localparam int F_IMPED = 0;
   localparam int F_BEMF = 1;
   localparam int F_FREQ = 2;
   localparam int F_SHORT = 3;
   localparam int F_TEMP = 4;
   localparam logic [7:0] SHAPE_SINE = 8'h01;

   typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_STANDBY, ST_DRIVE} hsc_state_t;
endpackage

//--- logic/hsc_top.sv
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module hsc_top #(
   parameter int IDLE_WAKE = hsc_pkg::IDLE_WAKE_CYC,
   parameter int STBY_WAKE = hsc_pkg::STBY_WAKE_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [2:0]  trigger_input,
   input  wire logic        seq_done,
   input  wire logic [7:0]  imped_meas,
   input  wire logic [7:0]  supply_meas,
   input  wire logic [2:0]  loop_fault,
   input  wire logic        short_det,
   input  wire logic        temp_warn,
   input  wire logic        temp_crit,
   output logic             fault_interrupt_n,
   output logic             bridge_out_positive,
   output logic             bridge_out_negative,
   output logic             bridge_oe,
   output logic             bemf_monitor_en,
   output logic [3:0]       closed_loop_feat,
   output logic [7:0]       wave_shape,
   output logic [7:0]       drive_level,
   output logic [2:0]       active_seq,
   output logic [1:0]       sys_state
);
   hsc_pkg::hsc_state_t st_r;
   logic [7:0]  ctrl_r;         // 0 standby_en, 1 embedded, 2 closed loop, 7:4 features
   logic [2:0]  mode_r;
   logic [5:0]  trig_edge_r;    // two bits per input
   logic [2:0]  trig_pair_r;
   logic [8:0]  seq_map_r;      // three bits per input, second sequence is +1
   logic [4:0]  fault_r;
   logic [7:0]  imped_r;
   logic [7:0]  supply_r;
   logic [7:0]  shape_r;
   logic [7:0]  level_r;
   logic [7:0]  mem_r [hsc_pkg::WAVE_BYTES];
   logic [2:0]  odd_r;
   logic [2:0]  sy1_r, sy2_r, sy3_r;
   logic        host_start_r;
   logic [2:0]  host_seq_r;
   logic [19:0] wake_cnt_r;
   logic        waking_r;
   logic [2:0]  pend_seq_r;
   logic [8:0]  pwm_cnt_r;
   logic        pwm_phase_r;
   logic [2:0]  stab_r;

   logic        acc;
   logic        wr_go;
   logic [6:0]  mem_idx;
   logic        mem_hit;
   logic [2:0]  trig_evt;
   logic        any_fault_now;
   logic        req;
   logic [2:0]  req_seq;

   // Refuse settings the counters and the index cannot hold
   if (IDLE_WAKE < hsc_pkg::WAKE_OVH || STBY_WAKE < hsc_pkg::WAKE_OVH || STBY_WAKE > IDLE_WAKE
       || IDLE_WAKE >= 2**$bits(wake_cnt_r) || hsc_pkg::WAVE_BYTES > 2**$bits(mem_idx)
       || hsc_pkg::PWM_DIV / 2 > 2**$bits(pwm_cnt_r)) begin : g_bad_cfg
      $error("hsc_top: wake counts out of range");
   end

   function automatic logic edge_fire(input logic [1:0] cfg, input logic p, input logic n);
      edge_fire = (cfg[0] && !p && n) || (cfg[1] && p && !n);
   endfunction

   // First cycle of a request; read data is fetched here
   assign acc = (avs_read || avs_write) && avs_waitrequest;
   // Writes land only on the edge that completes the transfer
   assign wr_go = avs_write && !avs_waitrequest;
   assign mem_hit = avs_address >= hsc_pkg::A_MEM && avs_address < hsc_pkg::A_MEM_END;
   assign mem_idx = 7'(avs_address - hsc_pkg::A_MEM);

   // bus served in every state
   // One wait cycle, then low for exactly one cycle
   always_ff @(posedge clk) begin
      if (rst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !acc;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (acc && avs_read) begin
         if (avs_address == hsc_pkg::A_CTRL)
            avs_readdata <= {24'h0, ctrl_r};
         else if (avs_address == hsc_pkg::A_MODE)
            avs_readdata <= {29'h0, mode_r};
         else if (avs_address == hsc_pkg::A_TRIG)
            avs_readdata <= {23'h0, trig_pair_r, trig_edge_r};
         else if (avs_address == hsc_pkg::A_SEQ)
            avs_readdata <= {23'h0, seq_map_r};
         else if (avs_address == hsc_pkg::A_STATUS)
            avs_readdata <= {24'h0, temp_warn, active_seq, 2'h0, sys_state};
         else if (avs_address == hsc_pkg::A_FAULT)
            avs_readdata <= {27'h0, fault_r};
         else if (avs_address == hsc_pkg::A_IMPED)
            avs_readdata <= {24'h0, imped_r};
         else if (avs_address == hsc_pkg::A_SUPPLY)
            avs_readdata <= {24'h0, supply_r};
         else if (avs_address == hsc_pkg::A_SHAPE)
            avs_readdata <= {24'h0, shape_r};
         else if (avs_address == hsc_pkg::A_LEVEL)
            avs_readdata <= {24'h0, level_r};
         else if (mem_hit)
            avs_readdata <= {24'h0, mem_r[mem_idx]};
         else
            avs_readdata <= 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= 8'h00;
         mode_r <= hsc_pkg::MODE_INACTIVE;
         trig_edge_r <= 6'h00;
         trig_pair_r <= 3'h0;
         seq_map_r <= 9'h000;
         shape_r <= hsc_pkg::SHAPE_SINE;
         level_r <= 8'h00;
      end else if (wr_go) begin
         if (avs_address == hsc_pkg::A_CTRL)
            ctrl_r <= avs_writedata[7:0];
         else if (avs_address == hsc_pkg::A_MODE)
            mode_r <= avs_writedata[2:0];
         else if (avs_address == hsc_pkg::A_TRIG) begin
            trig_edge_r <= avs_writedata[5:0];
            trig_pair_r <= avs_writedata[8:6];
         end else if (avs_address == hsc_pkg::A_SEQ)
            seq_map_r <= avs_writedata[8:0];
         else if (avs_address == hsc_pkg::A_SHAPE)
            shape_r <= avs_writedata[7:0];
         else if (avs_address == hsc_pkg::A_LEVEL)
            level_r <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (wr_go && mem_hit)
         mem_r[mem_idx] <= avs_writedata[7:0];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         host_start_r <= 1'b0;
         host_seq_r <= 3'h0;
      end else begin
         host_start_r <= wr_go && avs_address == hsc_pkg::A_START;
         if (wr_go && avs_address == hsc_pkg::A_START)
            host_seq_r <= avs_writedata[2:0];
      end
   end

   // Pins pass three flops, change counts when 2 and 3 agree
   always_ff @(posedge clk) begin
      if (rst) begin
         sy1_r <= 3'h0;
         sy2_r <= 3'h0;
         sy3_r <= 3'h0;
         stab_r <= 3'h0;
      end else begin
         sy1_r <= trigger_input;
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         // Settled level follows only where the last two stages agree
         stab_r <= (sy2_r & sy3_r) | (stab_r & (sy2_r | sy3_r));
      end
   end

   always_comb begin
      for (int i = 0; i < hsc_pkg::NUM_TRIG; i++)
         trig_evt[i] = sy2_r[i] == sy3_r[i]
                       && edge_fire(trig_edge_r[2*i +: 2], stab_r[i], sy3_r[i]);
   end

   always_ff @(posedge clk) begin
      if (rst)
         odd_r <= 3'h0;
      else
         for (int i = 0; i < hsc_pkg::NUM_TRIG; i++)
            if (trig_evt[i] && st_r != hsc_pkg::ST_DRIVE && !waking_r)
               odd_r[i] <= trig_pair_r[i] ? !odd_r[i] : 1'b0;
   end

   always_comb begin
      req_seq = host_seq_r;
      req = host_start_r && (mode_r == hsc_pkg::MODE_REGMEM || mode_r == hsc_pkg::MODE_EDGEMEM);
      for (int i = hsc_pkg::NUM_TRIG - 1; i >= 0; i--)
         if (mode_r == hsc_pkg::MODE_EDGEMEM && trig_evt[i]) begin
            req = 1'b1;
            req_seq = seq_map_r[3*i +: 3] + 3'(odd_r[i]);
         end
      if (mode_r == hsc_pkg::MODE_STREAM || mode_r == hsc_pkg::MODE_PWMIN)
         req = 1'b1;
   end

   assign any_fault_now = |loop_fault && ctrl_r[2] || short_det || temp_crit;

   // fault flags, set wins over clear
   always_ff @(posedge clk) begin
      if (rst)
         fault_r <= 5'h00;
      else begin
         if (wr_go && avs_address == hsc_pkg::A_FAULT)
            fault_r <= fault_r & ~avs_writedata[4:0];
         else if (ctrl_r[1] && req && st_r != hsc_pkg::ST_DRIVE)
            fault_r <= 5'h00;
         if (ctrl_r[2]) begin
            if (loop_fault[0])
               fault_r[hsc_pkg::F_IMPED] <= 1'b1;
            if (loop_fault[1])
               fault_r[hsc_pkg::F_BEMF] <= 1'b1;
            if (loop_fault[2])
               fault_r[hsc_pkg::F_FREQ] <= 1'b1;
         end
         if (short_det)
            fault_r[hsc_pkg::F_SHORT] <= 1'b1;
         if (temp_crit)
            fault_r[hsc_pkg::F_TEMP] <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         fault_interrupt_n <= 1'b1;
      else
         fault_interrupt_n <= !(|fault_r);
   end

   // Main state machine
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= hsc_pkg::ST_BOOT;
         waking_r <= 1'b0;
         wake_cnt_r <= 20'h0;
         pend_seq_r <= 3'h0;
         active_seq <= 3'h0;
      end else if (any_fault_now) begin
         st_r <= hsc_pkg::ST_IDLE;
         waking_r <= 1'b0;
      end else begin
         case (st_r)
            hsc_pkg::ST_BOOT:
               st_r <= hsc_pkg::ST_IDLE;
            hsc_pkg::ST_IDLE, hsc_pkg::ST_STANDBY: begin
               if (!waking_r && req && (fault_r == 5'h0 || ctrl_r[1])) begin
                  waking_r <= 1'b1;
                  pend_seq_r <= req_seq;
                  wake_cnt_r <= 20'(st_r == hsc_pkg::ST_IDLE ? IDLE_WAKE - hsc_pkg::WAKE_OVH
                                                             : STBY_WAKE - hsc_pkg::WAKE_OVH);
               end else if (waking_r && wake_cnt_r != 20'h0) begin
                  wake_cnt_r <= wake_cnt_r - 20'h1;
               end else if (waking_r) begin
                  st_r <= hsc_pkg::ST_DRIVE;
                  waking_r <= 1'b0;
                  active_seq <= pend_seq_r;
               end
            end
            hsc_pkg::ST_DRIVE:
               if (seq_done || mode_r == hsc_pkg::MODE_INACTIVE)
                  st_r <= ctrl_r[0] ? hsc_pkg::ST_STANDBY : hsc_pkg::ST_IDLE;
            default:
               st_r <= hsc_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         sys_state <= 2'h0;
      else
         sys_state <= 2'(st_r);
   end

   always_ff @(posedge clk) begin
      if (rst)
         imped_r <= 8'h00;
      else if (waking_r && wake_cnt_r == 20'h0 && st_r != hsc_pkg::ST_DRIVE)
         imped_r <= imped_meas;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         supply_r <= 8'h00;
         drive_level <= 8'h00;
      end else begin
         supply_r <= supply_meas;
         drive_level <= level_r > supply_r ? supply_r : level_r;
      end
   end

   // open loop: no monitoring or adjustment
   always_ff @(posedge clk) begin
      if (rst) begin
         bemf_monitor_en <= 1'b0;
         closed_loop_feat <= 4'h0;
         wave_shape <= hsc_pkg::SHAPE_SINE;
      end else begin
         bemf_monitor_en <= ctrl_r[2];
         closed_loop_feat <= ctrl_r[2] ? ctrl_r[7:4] : 4'h0;
         wave_shape <= ctrl_r[2] ? 8'h00 : shape_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_cnt_r <= 9'h000;
         pwm_phase_r <= 1'b0;
      end else if (pwm_cnt_r == 9'(hsc_pkg::PWM_DIV / 2 - 1)) begin
         pwm_cnt_r <= 9'h000;
         pwm_phase_r <= !pwm_phase_r;
      end else
         pwm_cnt_r <= pwm_cnt_r + 9'h001;
   end

   // bridge off on short or any fault
   always_ff @(posedge clk) begin
      if (rst) begin
         bridge_oe <= 1'b0;
         bridge_out_positive <= 1'b0;
         bridge_out_negative <= 1'b0;
      end else begin
         bridge_oe <= st_r == hsc_pkg::ST_DRIVE && !any_fault_now && !short_det;
         bridge_out_positive <= pwm_phase_r;
         bridge_out_negative <= !pwm_phase_r;
      end
   end
endmodule
